// >>> rtl/clk_net.sv
// Clock and control source selection network with static configuration
//
// How it works
// - Eight primary and eight secondary lines
// - Primary lines pick among six source kinds
// - Six clock pads, two per side
// - Secondary sources from pads, else routing
// - Lines 0-3 control, 4-7 clock
// - Line 7 also feeds set/reset or enable
// - Lines 0-2 also usable as clocks
// - Secondary distribution over twenty regions
// - Eight secondary resources in each region
// - Region lines carry controls as well
// - Global secondary line reaches every region
// - Slice clock: primaries, seven secondaries, routing
// - Slice control: secondaries or routing
// - Nothing chosen drives constant one
// - Slices 0-2 have muxes, slice 3 none
// - Two edge clocks on three edges
// - Edge clocks drive I/O registers
// - Sources: pads, loops, dividers, routing
module clk_net
   import clk_net_pkg::*;
#(
   parameter int N_PLL   = 10,
   parameter int N_DIV   = 4,
   parameter int N_ROUTE = 16,
   parameter int N_QUAD  = 4
)
(
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   resetn,
   // Clock sources, asynchronous to clk
   input  wire logic [N_PLL-1:0]       pll_clk,
   input  wire logic [1:0]             dll_clk,
   input  wire logic [N_DIV-1:0]       divided_clock_output,
   input  wire logic [5:0]             pad_clk,
   input  wire logic [N_ROUTE-1:0]     route_sig,
   input  wire logic [N_QUAD-1:0]      quad_clk,
   // Primary line selections
   input  wire logic [7:0][2:0]        cfg_prim_cat,
   input  wire logic [7:0][3:0]        cfg_prim_idx,
   // Secondary line selections
   input  wire logic [7:0]             cfg_sec_use_pad,
   input  wire logic [7:0][2:0]        cfg_sec_pad_idx,
   input  wire logic [7:0][3:0]        cfg_sec_route_idx,
   input  wire logic [7:0]             cfg_sec_global,
   input  wire logic [19:0][7:0]       cfg_region_en,
   // Edge clock selections
   input  wire logic [5:0][2:0]        cfg_edge_cat,
   input  wire logic [5:0][3:0]        cfg_edge_idx,
   // Slice selections
   input  wire logic [4:0]             cfg_slice_region,
   input  wire logic [2:0][4:0]        cfg_slice_clk_sel,
   input  wire logic [2:0][2:0]        cfg_slice_ce_sel,
   input  wire logic [2:0][2:0]        cfg_slice_lsr_sel,
   // Network outputs
   output logic [7:0]                  primary_clk,
   output logic [7:0]                  secondary_source_lines,
   output logic [19:0][7:0]            region_sec,
   output logic [5:0]                  edge_clk,
   output logic [2:0]                  slice_clk,
   output logic [2:0]                  slice_ce,
   output logic [2:0]                  local_set_reset_control,
   output logic                        cfg_done
);
`include "clk_net_consts.svh"

   // ==========================================================
   // Source vector layout
   localparam int OFF_PLL   = 0;
   localparam int OFF_DLL   = OFF_PLL + N_PLL;
   localparam int OFF_DIV   = OFF_DLL + `NUM_DLL_OUT;
   localparam int OFF_PAD   = OFF_DIV + N_DIV;
   localparam int OFF_ROUTE = OFF_PAD + `NUM_CLK_PADS;
   localparam int OFF_QUAD  = OFF_ROUTE + N_ROUTE;
   localparam int SRC_W     = OFF_QUAD + N_QUAD;

   typedef struct packed {
      cfg_phase_t          phase;
      logic [SRC_W-1:0]    sync1;
      logic [SRC_W-1:0]    sync2;
      logic [7:0][2:0]     prim_cat;
      logic [7:0][3:0]     prim_idx;
      logic [7:0]          sec_use_pad;
      logic [7:0][2:0]     sec_pad_idx;
      logic [7:0][3:0]     sec_route_idx;
      logic [7:0]          sec_global;
      logic [19:0][7:0]    region_en;
      logic [5:0][2:0]     edge_cat;
      logic [5:0][3:0]     edge_idx;
      logic [4:0]          slice_region;
      logic [2:0][4:0]     slice_clk_sel;
      logic [2:0][2:0]     slice_ce_sel;
      logic [2:0][2:0]     slice_lsr_sel;
      logic [7:0]          prim;
      logic [7:0]          sec;
      logic [19:0][7:0]    region;
      logic [5:0]          edge_out;
   } net_state_t;

   net_state_t       state_reg;
   net_state_t       state_next;
   logic [SRC_W-1:0] src_in;
   logic [7:0]       slice_lines;

   assign src_in = {quad_clk, route_sig, pad_clk, divided_clock_output, dll_clk, pll_clk};

   // ==========================================================
   // Source pick by category and index; out of range reads as 0
   function automatic logic pick(input logic [2:0] cat, input logic [3:0] idx,
                                 input logic [SRC_W-1:0] v);
      logic r;
      int   i;
      r = 1'b0;
      i = int'(idx);
      case (cat)
         CAT_PLL:   if (i < N_PLL)         r = v[OFF_PLL + i];
         CAT_DLL:   if (i < `NUM_DLL_OUT)  r = v[OFF_DLL + i];
         CAT_DIV:   if (i < N_DIV)         r = v[OFF_DIV + i];
         CAT_PAD:   if (i < `NUM_CLK_PADS) r = v[OFF_PAD + i];
         CAT_ROUTE: if (i < N_ROUTE)       r = v[OFF_ROUTE + i];
         CAT_QUAD:  if (i < N_QUAD)        r = v[OFF_QUAD + i];
         default:   r = 1'b0;
      endcase
      return r;
   endfunction

   // ==========================================================
   // Next state of the whole network
   always_comb
   begin
      state_next = state_reg;
      // Two flops on every source before any mux reads it
      state_next.sync1 = src_in;
      state_next.sync2 = state_reg.sync1;

      // Selections are caught once after reset and then frozen, so a
      // stray change on the config pins can never glitch a clock
      case (state_reg.phase)
         CFG_LOAD:
         begin
            state_next.prim_cat      = cfg_prim_cat;
            state_next.prim_idx      = cfg_prim_idx;
            state_next.sec_use_pad   = cfg_sec_use_pad;
            state_next.sec_pad_idx   = cfg_sec_pad_idx;
            state_next.sec_route_idx = cfg_sec_route_idx;
            state_next.sec_global    = cfg_sec_global;
            state_next.region_en     = cfg_region_en;
            state_next.edge_cat      = cfg_edge_cat;
            state_next.edge_idx      = cfg_edge_idx;
            state_next.slice_region  = cfg_slice_region;
            state_next.slice_clk_sel = cfg_slice_clk_sel;
            state_next.slice_ce_sel  = cfg_slice_ce_sel;
            state_next.slice_lsr_sel = cfg_slice_lsr_sel;
            state_next.phase         = CFG_RUN;
         end
         CFG_RUN:
            state_next.phase = CFG_RUN;
         default:
            state_next.phase = CFG_LOAD;
      endcase

      // Eight quadrant primary lines over six source kinds
      for (int p = 0; p < `NUM_PRIMARY; p++)
         state_next.prim[p] = pick(state_reg.prim_cat[p], state_reg.prim_idx[p],
                                   state_reg.sync2);

      // Secondary sources: a pad where chosen, otherwise routing
      for (int s = 0; s < `NUM_SECONDARY; s++)
         state_next.sec[s] = state_reg.sec_use_pad[s]
            ? pick(CAT_PAD, {1'b0, state_reg.sec_pad_idx[s]}, state_reg.sync2)
            : pick(CAT_ROUTE, state_reg.sec_route_idx[s], state_reg.sync2);

      // Each region gets its enabled lines; global lines reach all
      for (int g = 0; g < `NUM_REGIONS; g++)
         state_next.region[g] = state_reg.sec &
            (state_reg.sec_global | state_reg.region_en[g]);

      // Edge clocks take pads, loops, dividers or routing only
      for (int e = 0; e < `NUM_EDGE_CLK; e++)
         state_next.edge_out[e] = (state_reg.edge_cat[e] == CAT_QUAD) ? 1'b0
            : pick(state_reg.edge_cat[e], state_reg.edge_idx[e], state_reg.sync2);
   end

   // ==========================================================
   // State register; constants only under reset
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg       <= '0;
         state_reg.phase <= CFG_LOAD;
      end
      else
         state_reg <= state_next;
   end

   // Region feeding the slices; out-of-range region reads as idle 0
   always_comb
   begin
      slice_lines = 8'h00;
      if (state_reg.slice_region < 5'(`NUM_REGIONS))
         slice_lines = state_reg.region[state_reg.slice_region];
   end

   // ==========================================================
   // Slices 0..2 carry registers; slice 3 has no mux at all
   for (genvar k = 0; k < `NUM_REG_SLICES; k++)
   begin : g_slice
      slice_sel u_slice (
         .clk          (clk),
         .resetn       (resetn),
         .primary_clk  (state_reg.prim),
         .region_lines (slice_lines),
         .route_clk    (state_reg.sync2[OFF_ROUTE + k]),
         .route_ctl    (state_reg.sync2[OFF_ROUTE + `NUM_REG_SLICES + k]),
         .clk_sel      (state_reg.slice_clk_sel[k]),
         .ce_sel       (state_reg.slice_ce_sel[k]),
         .lsr_sel      (state_reg.slice_lsr_sel[k]),
         .slice_clk    (slice_clk[k]),
         .slice_ce     (slice_ce[k]),
         .slice_lsr    (local_set_reset_control[k])
      );
   end

   // Outputs straight from the state register
   assign primary_clk            = state_reg.prim;
   assign secondary_source_lines = state_reg.sec;
   assign region_sec             = state_reg.region;
   assign edge_clk               = state_reg.edge_out;
   assign cfg_done               = state_reg.phase[1];  // Run bit of the one-hot phase

   // ==========================================================
   // Checks
   property p_cfg_static;
      @(posedge clk) disable iff (!resetn)
      (state_reg.phase == CFG_RUN) |=> $stable(state_reg.prim_cat) && $stable(state_reg.region_en)
         && $stable(state_reg.slice_clk_sel) && (state_reg.phase == CFG_RUN);
   endproperty
   a_cfg_static: assert property (p_cfg_static) else $error("selection changed in run");

   property p_load_once;
      @(posedge clk) disable iff (!resetn)
      (state_reg.phase == CFG_LOAD) |=> (state_reg.phase == CFG_RUN);
   endproperty
   a_load_once: assert property (p_load_once) else $error("config not taken in one cycle");

   // Source checks wait three run cycles, so sync flops cleared by reset drop out
   property p_prim_pad;
      @(posedge clk) disable iff (!resetn)
      (cfg_done && $past(cfg_done) && $past(cfg_done, 2) && state_reg.prim_cat[3] == CAT_PAD
         && state_reg.prim_idx[3] == 4'h5) |-> (primary_clk[3] == $past(pad_clk[5], 3));
   endproperty
   a_prim_pad: assert property (p_prim_pad) else $error("primary 3 not pad 5");

   property p_prim_dll;
      @(posedge clk) disable iff (!resetn)
      (cfg_done && $past(cfg_done) && $past(cfg_done, 2) && state_reg.prim_cat[1] == CAT_DLL
         && state_reg.prim_idx[1] == 4'h1) |-> (primary_clk[1] == $past(dll_clk[1], 3));
   endproperty
   a_prim_dll: assert property (p_prim_dll) else $error("primary 1 not loop 1");

   property p_prim_quad;
      @(posedge clk) disable iff (!resetn)
      (cfg_done && $past(cfg_done) && $past(cfg_done, 2) && state_reg.prim_cat[5] == CAT_QUAD
         && state_reg.prim_idx[5] == 4'h2) |-> (primary_clk[5] == $past(quad_clk[2], 3));
   endproperty
   a_prim_quad: assert property (p_prim_quad) else $error("primary 5 not quad 2");

   property p_prim_route;
      @(posedge clk) disable iff (!resetn)
      (cfg_done && $past(cfg_done) && $past(cfg_done, 2) && state_reg.prim_cat[4] == CAT_ROUTE
         && state_reg.prim_idx[4] == 4'h7)
         |-> (primary_clk[4] == $past(route_sig[7], 3));
   endproperty
   a_prim_route: assert property (p_prim_route) else $error("primary 4 not routing 7");

   property p_prim_range;
      @(posedge clk) disable iff (!resetn)
      (cfg_done && state_reg.prim_cat[6] == CAT_PLL && int'(state_reg.prim_idx[6]) >= N_PLL)
         |=> !primary_clk[6];
   endproperty
   a_prim_range: assert property (p_prim_range) else $error("bad loop index not 0");

   property p_sec_pad;
      @(posedge clk) disable iff (!resetn)
      (cfg_done && $past(cfg_done) && $past(cfg_done, 2) && state_reg.sec_use_pad[0]
         && state_reg.sec_pad_idx[0] == 3'h0)
         |-> (secondary_source_lines[0] == $past(pad_clk[0], 3));
   endproperty
   a_sec_pad: assert property (p_sec_pad) else $error("secondary 0 not pad 0");

   property p_sec_route;
      @(posedge clk) disable iff (!resetn)
      (cfg_done && $past(cfg_done) && $past(cfg_done, 2) && !state_reg.sec_use_pad[7]
         && state_reg.sec_route_idx[7] == 4'hf)
         |-> (secondary_source_lines[7] == $past(route_sig[15], 3));
   endproperty
   a_sec_route: assert property (p_sec_route) else $error("secondary 7 not routing 15");

   property p_global;
      @(posedge clk) disable iff (!resetn)
      (cfg_done && state_reg.sec_global[0]) |=>
         (region_sec[0][0] == $past(secondary_source_lines[0]))
         && (region_sec[19][0] == $past(secondary_source_lines[0]));
   endproperty
   a_global: assert property (p_global) else $error("global line missing in a region");

   property p_region_off;
      @(posedge clk) disable iff (!resetn)
      (cfg_done && !state_reg.sec_global[4] && !state_reg.region_en[12][4]) |=> !region_sec[12][4];
   endproperty
   a_region_off: assert property (p_region_off) else $error("disabled region line active");

   property p_edge_pll;
      @(posedge clk) disable iff (!resetn)
      (cfg_done && $past(cfg_done) && $past(cfg_done, 2) && state_reg.edge_cat[0] == CAT_PLL
         && state_reg.edge_idx[0] == 4'h0) |-> (edge_clk[0] == $past(pll_clk[0], 3));
   endproperty
   a_edge_pll: assert property (p_edge_pll) else $error("edge 0 not loop 0");

   property p_edge_quad;
      @(posedge clk) disable iff (!resetn)
      (cfg_done && state_reg.edge_cat[5] == CAT_QUAD) |=> !edge_clk[5];
   endproperty
   a_edge_quad: assert property (p_edge_quad) else $error("quad source on edge 5");

   property p_region_on;
      @(posedge clk) disable iff (!resetn)
      (cfg_done && state_reg.region_en[12][6])
         |=> (region_sec[12][6] == $past(secondary_source_lines[6]));
   endproperty
   a_region_on: assert property (p_region_on) else $error("enabled region line missing");

   c_prim_pad: cover property (@(posedge clk) disable iff (!resetn)
      cfg_done && state_reg.prim_cat[3] == CAT_PAD ##3 primary_clk[3]);
   c_global: cover property (@(posedge clk) disable iff (!resetn)
      cfg_done && state_reg.sec_global[0] && region_sec[19][0]);
   c_edge: cover property (@(posedge clk) disable iff (!resetn)
      cfg_done && edge_clk[3]);
endmodule

// >>> rtl/clk_net_consts.svh
// Constants of the clock and control selection network
`ifndef CLK_NET_CONSTS_SVH
`define CLK_NET_CONSTS_SVH

// Network dimensions
`define NUM_PRIMARY      8
`define NUM_SECONDARY    8
`define NUM_CLK_PADS     6
`define NUM_DLL_OUT      2
`define NUM_REGIONS      20
`define NUM_EDGE_CLK     6
`define NUM_REG_SLICES   3

// Slice clock select codes (5 bits)
`define CLK_SEL_NONE     5'h00
`define CLK_SEL_PRIM     5'h01
`define CLK_SEL_SEC      5'h09
`define CLK_SEL_ROUTE    5'h10

// Slice control select codes (3 bits)
`define CTL_SEL_NONE     3'h0
`define CTL_SEL_SEC      3'h1
`define CTL_SEL_SEC7     3'h5
`define CTL_SEL_ROUTE    3'h6

// Value driven when a slice multiplexer has nothing chosen
`define MUX_IDLE_VALUE   1'b1

// Synchroniser and network latency from source pin to primary output
`define SRC_TO_OUT_CYCLES 3

`endif

// >>> rtl/clk_net_pkg.sv
// Types shared by the clock and control selection network
package clk_net_pkg;

   // Source category of a primary or edge clock line
   typedef enum logic [2:0] {
      CAT_PLL   = 3'h0,
      CAT_DLL   = 3'h1,
      CAT_DIV   = 3'h2,
      CAT_PAD   = 3'h3,
      CAT_ROUTE = 3'h4,
      CAT_QUAD  = 3'h5
   } src_cat_t;

   // Configuration phase, one-hot
   typedef enum logic [1:0] {
      CFG_LOAD = 2'b01,
      CFG_RUN  = 2'b10
   } cfg_phase_t;

endpackage

// >>> rtl/slice_sel.sv
// Clock and control multiplexers of one register-bearing logic slice
module slice_sel
   import clk_net_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // Network lines
   input  wire logic [7:0] primary_clk,
   input  wire logic [7:0] region_lines,
   input  wire logic       route_clk,
   input  wire logic       route_ctl,
   // Static selections
   input  wire logic [4:0] clk_sel,
   input  wire logic [2:0] ce_sel,
   input  wire logic [2:0] lsr_sel,
   // Slice outputs
   output logic            slice_clk,
   output logic            slice_ce,
   output logic            slice_lsr
);
`include "clk_net_consts.svh"

   typedef struct packed {
      logic clk_out;
      logic ce_out;
      logic lsr_out;
   } slice_state_t;

   slice_state_t state_reg;
   slice_state_t state_next;
   logic [6:0]   sec_clk_set;

   // Only lines 0,1,2 and 4..7 reach the clock mux; line 3 is control only
   assign sec_clk_set = {region_lines[7:4], region_lines[2:0]};

   // Control mux shared by clock enable and set/reset
   function automatic logic ctl_pick(input logic [2:0] sel, input logic [7:0] lines,
                                     input logic route);
      logic r;
      r = `MUX_IDLE_VALUE;
      if (sel >= `CTL_SEL_SEC && sel < `CTL_SEL_SEC7)
         r = lines[2'(sel - `CTL_SEL_SEC)];
      else if (sel == `CTL_SEL_SEC7)
         r = lines[7];
      else if (sel == `CTL_SEL_ROUTE)
         r = route;
      return r;
   endfunction

   // Next values of the three multiplexers
   always_comb
   begin
      state_next = state_reg;
      state_next.clk_out = `MUX_IDLE_VALUE;
      if (clk_sel >= `CLK_SEL_PRIM && clk_sel < `CLK_SEL_SEC)
         state_next.clk_out = primary_clk[3'(clk_sel - `CLK_SEL_PRIM)];
      else if (clk_sel >= `CLK_SEL_SEC && clk_sel < `CLK_SEL_ROUTE)
         state_next.clk_out = sec_clk_set[3'(clk_sel - `CLK_SEL_SEC)];
      else if (clk_sel == `CLK_SEL_ROUTE)
         state_next.clk_out = route_clk;
      state_next.ce_out  = ctl_pick(ce_sel, region_lines, route_ctl);
      state_next.lsr_out = ctl_pick(lsr_sel, region_lines, route_ctl);
   end

   // State register
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   assign slice_clk = state_reg.clk_out;
   assign slice_ce  = state_reg.ce_out;
   assign slice_lsr = state_reg.lsr_out;

   // ==========================================================
   // Checks
   property p_clk_idle;
      @(posedge clk) disable iff (!resetn)
      (clk_sel == `CLK_SEL_NONE) [*2] |-> slice_clk;
   endproperty
   a_clk_idle: assert property (p_clk_idle) else $error("idle clock mux not 1");

   property p_ctl_idle;
      @(posedge clk) disable iff (!resetn)
      (ce_sel == `CTL_SEL_NONE && lsr_sel == `CTL_SEL_NONE) [*2] |-> (slice_ce && slice_lsr);
   endproperty
   a_ctl_idle: assert property (p_ctl_idle) else $error("idle control mux not 1");

   property p_sec7_ctl;
      @(posedge clk) disable iff (!resetn)
      (lsr_sel == `CTL_SEL_SEC7) |=> (slice_lsr == $past(region_lines[7]));
   endproperty
   a_sec7_ctl: assert property (p_sec7_ctl) else $error("line 7 not on set/reset");

   property p_sec3_ctl;
      @(posedge clk) disable iff (!resetn)
      (ce_sel == 3'h4) |=> (slice_ce == $past(region_lines[3]));
   endproperty
   a_sec3_ctl: assert property (p_sec3_ctl) else $error("line 3 not on enable");

   property p_sec_clk2;
      @(posedge clk) disable iff (!resetn)
      (clk_sel == 5'h0b) |=> (slice_clk == $past(region_lines[2]));
   endproperty
   a_sec_clk2: assert property (p_sec_clk2) else $error("line 2 not on clock");

   property p_sec_clk3;
      @(posedge clk) disable iff (!resetn)
      (clk_sel == 5'h0c) |=> (slice_clk == $past(region_lines[4]));
   endproperty
   a_sec_clk3: assert property (p_sec_clk3) else $error("fourth code not line 4");

   c_slice_idle: cover property (@(posedge clk) disable iff (!resetn)
      clk_sel == `CLK_SEL_NONE ##1 slice_clk);
endmodule

// >>> verif/io_regs_model.sv
// Model of the I/O registers that sit on the far side of the edge clocks
module io_regs_model
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // Edge clocks from the network
   input  wire logic [5:0] edge_clk,
   // Rising edges seen on each edge clock
   output logic [5:0][7:0] edge_rises
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [5:0] last_reg;

   // Each register bank counts its own clock; a dead edge clock shows no rises
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         last_reg   <= 6'h00;
         edge_rises <= '0;
      end
      else
      begin
         last_reg <= edge_clk;
         for (int i = 0; i < 6; i++)
            if (edge_clk[i] && !last_reg[i])
               edge_rises[i] <= edge_rises[i] + 8'h01;
      end
   end
endmodule

// >>> verif/testbench.sv
// Self-checking bench of the clock and control selection network
module testbench
   import clk_net_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================
   // Stimulus and observed signals
   localparam logic [41:0] pat_a = 42'h2a5_c36e_9b14;
   logic             clk, resetn, done_o;
   logic [9:0]       pll;
   logic [1:0]       dll;
   logic [3:0]       dvo, quad;
   logic [5:0]       pad, edge_o;
   logic [15:0]      rte;
   logic [7:0][2:0]  pcat, pcat_pin, spad;
   logic [7:0][3:0]  pidx, sridx;
   logic [5:0][2:0]  ecat;
   logic [5:0][3:0]  eidx;
   logic [19:0][7:0] ren, reg_o;
   logic [2:0][4:0]  csel;
   logic [2:0][2:0]  esel, lsel;
   logic [7:0]       prim_o, sec_o;
   logic [2:0]       sclk_o, sce_o, slsr_o;
   logic [5:0][7:0]  rises;
   int               miscompares, cmp_count;

   clk_net clk_net_inst (.clk(clk), .resetn(resetn), .pll_clk(pll), .dll_clk(dll),
      .divided_clock_output(dvo), .pad_clk(pad), .route_sig(rte), .quad_clk(quad),
      .cfg_prim_cat(pcat_pin), .cfg_prim_idx(pidx), .cfg_sec_use_pad(8'h0f),
      .cfg_sec_pad_idx(spad), .cfg_sec_route_idx(sridx), .cfg_sec_global(8'h0f),
      .cfg_region_en(ren), .cfg_edge_cat(ecat), .cfg_edge_idx(eidx),
      .cfg_slice_region(5'h00), .cfg_slice_clk_sel(csel), .cfg_slice_ce_sel(esel),
      .cfg_slice_lsr_sel(lsel), .primary_clk(prim_o), .secondary_source_lines(sec_o),
      .region_sec(reg_o), .edge_clk(edge_o), .slice_clk(sclk_o), .slice_ce(sce_o),
      .local_set_reset_control(slsr_o), .cfg_done(done_o));

   io_regs_model io_regs_model_inst (.clk(clk), .resetn(resetn), .edge_clk(edge_o),
      .edge_rises(rises));

   // ==========================================
   // Expected values
   function automatic logic pick(input logic [2:0] c, input logic [3:0] i, input logic q);
      case (c)
         3'h0: return (i < 4'ha) ? pll[i] : 1'b0;
         3'h1: return (i < 4'h2) ? dll[i[0]] : 1'b0;
         3'h2: return (i < 4'h4) ? dvo[i[1:0]] : 1'b0;
         3'h3: return (i < 4'h6) ? pad[i[2:0]] : 1'b0;
         3'h4: return rte[i];
         3'h5: return (q && i < 4'h4) ? quad[i[1:0]] : 1'b0;
         default: return 1'b0;
      endcase
   endfunction

   // Codes 9..15 skip secondary line 3, which is kept for controls
   function automatic logic sclk(input logic [4:0] c, input int k,
                                 input logic [7:0] ep, input logic [7:0] es);
      if (c == 5'h00 || c > 5'h10)
         return 1'b1;
      if (c <= 5'h08)
         return ep[c - 5'h01];
      if (c == 5'h10)
         return rte[k];
      return es[(c < 5'h0c) ? c - 5'h09 : c - 5'h08];
   endfunction

   function automatic logic sctl(input logic [2:0] c, input int k, input logic [7:0] es);
      if (c == 3'h0 || c == 3'h7)
         return 1'b1;
      if (c <= 3'h4)
         return es[c - 3'h1];
      return (c == 3'h5) ? es[7] : rte[3 + k];
   endfunction

   // ==========================================
   // Shared tasks
   task check(input logic [159:0] seen, input logic [159:0] expv);
      cmp_count++;
      if (seen !== expv)
      begin
         miscompares++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, expv);
      end
   endtask

   task check_all;
      logic [7:0]       ep, es;
      logic [5:0]       ee;
      logic [19:0][7:0] er;
      logic [2:0]       ec, ecl, el;
      es = {rte[15:12], pad[3:0]};
      for (int p = 0; p < 8; p++)
         ep[p] = pick(pcat[p], pidx[p], 1'b1);
      for (int e = 0; e < 6; e++)
         ee[e] = pick(ecat[e], eidx[e], 1'b0);
      for (int r = 0; r < 20; r++)
         for (int s = 0; s < 8; s++)
            er[r][s] = es[s] & (s < 4 || ren[r][s]);
      for (int k = 0; k < 3; k++)
      begin
         ec[k]  = sclk(csel[k], k, ep, er[0]);
         ecl[k] = sctl(esel[k], k, er[0]);
         el[k]  = sctl(lsel[k], k, er[0]);
      end
      check(prim_o, ep);
      check(sec_o, es);
      check(reg_o, er);
      check(edge_o, ee);
      check(sclk_o, ec);
      check({sce_o, slsr_o}, {ecl, el});
   endtask

   // Selections are taken once, at the first edge after release
   task start_run;
      @(negedge clk);
      resetn   = 1'b0;
      pcat_pin = pcat;
      repeat (10) @(negedge clk);
      check({prim_o, sec_o, edge_o, sclk_o, sce_o, slsr_o, done_o}, '0);
      resetn = 1'b1;
      repeat (2) @(negedge clk);
      check(done_o, 1'b1);
   endtask

   task apply(input logic [41:0] v);
      @(negedge clk);
      {pll, dll, dvo, pad, rte, quad} = v;
      repeat (8) @(negedge clk);
   endtask

   // ==========================================
   // Scenarios
   task slice_codes;
      for (int r = 0; r < 11; r++)
      begin
         for (int k = 0; k < 3; k++)
         begin
            csel[k] = 5'((3 * r + k) % 32);
            esel[k] = 3'((r + k) % 8);
            lsel[k] = 3'((r + k + 3) % 8);
         end
         start_run;
         apply(pat_a);
         check_all;
         apply(~pat_a);
         check_all;
      end
   endtask

   // A late change of selection must not reach the lines
   task cfg_frozen;
      start_run;
      @(negedge clk);
      pcat_pin = ~pcat;
      apply(pat_a);
      check_all;
      apply(~pat_a);
      check_all;
   endtask

   task edge_toggle;
      logic [5:0][7:0] expr;
      start_run;
      apply(42'h0);
      expr = rises;
      for (int e = 0; e < 5; e++)
         expr[e] = expr[e] + 8'h04;
      repeat (4)
      begin
         apply('1);
         apply(42'h0);
      end
      check(rises, expr);
   endtask

   task complete_run;
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ==========================================
   // Clock, watchdog and main sequence
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      complete_run;
   end

   initial
   begin
      resetn = 1'b0;
      {pll, dll, dvo, pad, rte, quad} = 42'h0;
      csel = '0;
      esel = '0;
      lsel = '0;
      pcat = {CAT_PLL, CAT_PLL, CAT_QUAD, CAT_ROUTE, CAT_PAD, CAT_DIV, CAT_DLL, CAT_PLL};
      pidx = {4'h9, 4'hc, 4'h2, 4'h7, 4'h5, 4'h2, 4'h1, 4'h3};
      ecat = {CAT_QUAD, CAT_ROUTE, CAT_PAD, CAT_DIV, CAT_DLL, CAT_PLL};
      eidx = {4'h0, 4'h1, 4'h0, 4'h3, 4'h0, 4'h0};
      pcat_pin = pcat;
      for (int s = 0; s < 8; s++)
      begin
         spad[s]  = 3'(s);
         sridx[s] = 4'(s + 8);
      end
      for (int r = 0; r < 20; r++)
         for (int s = 0; s < 8; s++)
            ren[r][s] = ((r + s) % 3 == 0);
      slice_codes;
      cfg_frozen;
      edge_toggle;
      complete_run;
   end
endmodule
